// [design/mtc_top.sv]
// memory timing control: one 16-bit control word behind an AXI4-Lite slave,
// decoded timing for the external memory sequencer, activate hold-off and
// the refresh / self-refresh request machine.
// assumes the sequencer pulses its events for one aclk cycle and keeps mem_kind static.
`timescale 1ns/10ps
`include "mtc_regs.svh"
module mtc_top
  import mtc_pkg::*;
#(
  parameter int TIMER_W = 4
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`MTC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`MTC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire mtc_mem_kind_t          mem_kind,
  input  wire logic                   bus_cycle_active,
  input  wire logic                   refresh_tick,
  input  wire logic                   precharge_done,
  input  wire logic                   sdram_write_end,
  input  wire logic                   sdram_autorefresh,
  output mtc_timing_t                 timing,
  output logic                        activate_hold,
  output logic                        refresh_start,
  output logic                        bus_end_req,
  output logic                        self_refresh_active
);
  if (TIMER_W < 4) begin : g_bad_timer
    $error("mtc_top: TIMER_W must be at least 4");
  end

  logic [`MTC_CTRL_W-1:0]  ctrl_q;
  logic [`MTC_CTRL_W-1:0]  ctrl_d;
  logic                    aw_full_q;
  logic                    w_full_q;
  logic [`MTC_ADDR_W-1:0]  aw_addr_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    awready_q;
  logic                    wready_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    arready_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  mtc_rf_state_t           rf_q;
  mtc_rf_state_t           rf_d;
  logic                    pend_q;
  logic                    refresh_start_q;
  logic                    bus_end_req_q;
  logic                    self_q;
  logic                    sr_exit_q;
  mtc_timing_t             timing_q;

  // AXI4-Lite write side: address and data are held independently
  wire aw_take   = s_axi_awvalid && awready_q;
  wire w_take    = s_axi_wvalid && wready_q;
  wire commit    = aw_full_q && w_full_q && !bvalid_q;
  wire aw_full_d = (aw_full_q && !commit) || aw_take;
  wire w_full_d  = (w_full_q && !commit) || w_take;
  wire bvalid_d  = (bvalid_q && !s_axi_bready) || commit;
  wire wr_ctrl   = commit && ({aw_addr_q[`MTC_ADDR_W-1:2], 2'b00} == `MTC_CTRL_OFFSET);
  wire wr_stat   = commit && ({aw_addr_q[`MTC_ADDR_W-1:2], 2'b00} == `MTC_STAT_OFFSET);
  wire wr_hit    = wr_ctrl || wr_stat;

  // byte lanes 0 and 1 carry the 16-bit word; reserved bit 7 never stores
  wire [`MTC_CTRL_W-1:0] lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [`MTC_CTRL_W-1:0] wr_mask   = lane_mask & `MTC_CTRL_WMASK;
  wire [`MTC_CTRL_W-1:0] merged    = (ctrl_q & ~wr_mask) | (w_data_q[`MTC_CTRL_W-1:0] & wr_mask);
  // the reserved write-precharge code cannot be set: the old code stays
  wire write_to_precharge_delay_bad = (merged[`MTC_WRITE_TO_PRECHARGE_DELAY_HI:`MTC_WRITE_TO_PRECHARGE_DELAY_LO] == `MTC_WRITE_TO_PRECHARGE_DELAY_RSVD);
  wire [`MTC_CTRL_W-1:0] merged_ok = write_to_precharge_delay_bad ?
    {merged[`MTC_CTRL_W-1:`MTC_RCD_LO], ctrl_q[`MTC_WRITE_TO_PRECHARGE_DELAY_HI:`MTC_WRITE_TO_PRECHARGE_DELAY_LO],
     merged[`MTC_REFRESH_ROW_ASSERT_TIME_HI:0]} : merged;
  assign ctrl_d = wr_ctrl ? merged_ok : ctrl_q;

  // AXI4-Lite read side
  wire ar_take  = s_axi_arvalid && arready_q;
  wire rvalid_d = (rvalid_q && !s_axi_rready) || ar_take;
  wire rd_ctrl  = ({s_axi_araddr[`MTC_ADDR_W-1:2], 2'b00} == `MTC_CTRL_OFFSET);
  wire rd_stat  = ({s_axi_araddr[`MTC_ADDR_W-1:2], 2'b00} == `MTC_STAT_OFFSET);
  wire [31:0] stat_word = {28'h0000000, (rf_q == RF_SRWAIT), activate_hold, pend_q, self_q};
  wire [31:0] rd_word   = rd_ctrl ? {16'h0000, ctrl_q} : (rd_stat ? stat_word : 32'h00000000);

  // only aresetn clears the word; manual reset and standby never reach it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `MTC_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `MTC_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q  <= !w_full_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (commit) begin
        bresp_q <= wr_hit ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `MTC_RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= (rd_ctrl || rd_stat) ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
      end
    end
  end

  // field decode
  wire [1:0] tpc_c  = ctrl_q[`MTC_TPC_HI:`MTC_TPC_LO];
  wire [1:0] rcd_c  = ctrl_q[`MTC_RCD_HI:`MTC_RCD_LO];
  wire [1:0] write_to_precharge_delay_c = ctrl_q[`MTC_WRITE_TO_PRECHARGE_DELAY_HI:`MTC_WRITE_TO_PRECHARGE_DELAY_LO];
  wire [1:0] refresh_row_assert_time_c = ctrl_q[`MTC_REFRESH_ROW_ASSERT_TIME_HI:`MTC_REFRESH_ROW_ASSERT_TIME_LO];
  wire [1:0] amx_c  = ctrl_q[`MTC_AMX_HI:`MTC_AMX_LO];
  wire refresh_on   = ctrl_q[`MTC_REFRESH_ON_BIT];
  wire refresh_kind = ctrl_q[`MTC_KIND_BIT];
  wire is_dram      = (mem_kind == MK_DRAM);
  wire is_sdram     = (mem_kind == MK_SDRAM);
  wire dynamic_mem  = (mem_kind != MK_NORMAL);

  wire [3:0] tpc_n  = {2'b00, tpc_c} + `MTC_TPC_BASE;
  // right after self-refresh the gap grows in steps of three
  wire [3:0] tpc_sr = {2'b00, tpc_c} + {1'b0, tpc_c, 1'b0} + `MTC_TPC_SR_BASE;
  wire [2:0] rcd_n  = {1'b0, rcd_c} + `MTC_RCD_BASE;
  wire [1:0] write_to_precharge_delay_n = write_to_precharge_delay_c + `MTC_WRITE_TO_PRECHARGE_DELAY_BASE;
  wire [2:0] refresh_row_assert_time_n = {1'b0, refresh_row_assert_time_c} + `MTC_REFRESH_ROW_ASSERT_TIME_BASE;

  wire [3:0] sdram_shift = (amx_c == 2'h0) ? `MTC_SDRAM_SHIFT0 :
                           (amx_c == 2'h1) ? `MTC_SDRAM_SHIFT1 :
                           (amx_c == 2'h2) ? `MTC_SDRAM_SHIFT2 : `MTC_SDRAM_SHIFT3;
  wire [3:0] dram_shift  = {2'b00, amx_c} + `MTC_DRAM_COL_BASE;

  mtc_timing_t timing_d;
  assign timing_d.precharge_cycles         = tpc_n;
  assign timing_d.row_to_column_delay      = rcd_n;
  assign timing_d.write_to_precharge_delay = write_to_precharge_delay_n;
  assign timing_d.refresh_row_assert_time  = refresh_row_assert_time_n;
  assign timing_d.burst_enable             = is_sdram || ctrl_q[`MTC_BURST_BIT];
  assign timing_d.memory_width_32          = ctrl_q[`MTC_WIDTH_BIT];
  assign timing_d.row_shift = is_dram ? dram_shift : (is_sdram ? sdram_shift : 4'h0);
  // extended-out timing only changes DRAM; other kinds keep normal sampling
  assign timing_d.sample_rising            = is_dram && ctrl_q[`MTC_EDO_BIT];
  assign timing_d.ras_negate_half_delay    = is_dram && ctrl_q[`MTC_EDO_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_q <= '0;
    end else begin
      timing_q <= timing_d;
    end
  end

  // activate hold-off: the longest pending gap wins inside the timer
  wire [3:0] gap_wr = tpc_n + {2'b00, write_to_precharge_delay_n};
  wire [3:0] gap_ar = tpc_n + {1'b0, refresh_row_assert_time_n};
  wire ld_pre = precharge_done;
  wire ld_wr  = is_sdram && sdram_write_end;
  wire ld_ar  = is_sdram && sdram_autorefresh;
  wire ld_sr  = sr_exit_q && is_dram;
  wire [3:0] v_pre = ld_pre ? tpc_n : 4'h0;
  wire [3:0] v_wr  = ld_wr ? gap_wr : 4'h0;
  wire [3:0] v_ar  = ld_ar ? gap_ar : 4'h0;
  wire [3:0] v_sr  = ld_sr ? tpc_sr : 4'h0;
  wire [3:0] v_a   = (v_pre > v_wr) ? v_pre : v_wr;
  wire [3:0] v_b   = (v_ar > v_sr) ? v_ar : v_sr;
  wire [3:0] v_max = (v_a > v_b) ? v_a : v_b;
  wire gap_load    = ld_pre || ld_wr || ld_ar || ld_sr;

  mtc_gap_timer #(
    .W (TIMER_W)
  ) u_gap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (gap_load),
    .value   (TIMER_W'(v_max)),
    .busy    (activate_hold)
  );

  // refresh request machine
  wire rf_enabled = refresh_on && dynamic_mem;
  wire want_self  = rf_enabled && refresh_kind;
  wire tick_ok    = rf_enabled && !refresh_kind && refresh_tick;

  always_comb begin
    rf_d = rf_q;
    unique case (rf_q)
      RF_IDLE: begin
        if (want_self) begin
          rf_d = RF_SRWAIT;
        end else if (tick_ok && bus_cycle_active) begin
          rf_d = RF_ENDING;
        end
      end
      RF_ENDING: begin
        if (!bus_cycle_active || !rf_enabled) begin
          rf_d = RF_IDLE;
        end
      end
      RF_SRWAIT: begin
        if (!want_self) begin
          rf_d = RF_IDLE;
        end else if (!bus_cycle_active) begin
          rf_d = RF_SELF;
        end
      end
      RF_SELF: begin
        if (!want_self) begin
          rf_d = RF_IDLE;
        end
      end
    endcase
  end

  // start fires on an idle-bus tick, or when the ended bus cycle clears
  wire start_now = (rf_q == RF_IDLE && !want_self && tick_ok && !bus_cycle_active) ||
                   (rf_q == RF_ENDING && !bus_cycle_active && rf_enabled);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_q            <= RF_IDLE;
      pend_q          <= 1'b0;
      refresh_start_q <= 1'b0;
      bus_end_req_q   <= 1'b0;
      self_q          <= 1'b0;
      sr_exit_q       <= 1'b0;
    end else begin
      rf_q            <= rf_d;
      // ticks seen in self-refresh never reach the start strobe
      refresh_start_q <= start_now && (rf_q != RF_SELF);
      pend_q          <= (rf_d == RF_ENDING);
      bus_end_req_q   <= (rf_d == RF_ENDING);
      self_q          <= (rf_d == RF_SELF);
      sr_exit_q       <= (rf_q == RF_SELF) && (rf_d != RF_SELF);
    end
  end

  assign s_axi_awready       = awready_q;
  assign s_axi_wready        = wready_q;
  assign s_axi_bvalid        = bvalid_q;
  assign s_axi_bresp         = bresp_q;
  assign s_axi_arready       = arready_q;
  assign s_axi_rvalid        = rvalid_q;
  assign s_axi_rdata         = rdata_q;
  assign s_axi_rresp         = rresp_q;
  assign timing              = timing_q;
  assign refresh_start       = refresh_start_q;
  assign bus_end_req         = bus_end_req_q;
  assign self_refresh_active = self_q;

  chk_reset_clears_word: assert property (@(posedge aclk)
    !aresetn |=> (ctrl_q == `MTC_CTRL_RESET)) else $error("word not cleared by reset");
  chk_reserved_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[`MTC_RSVD_BIT] == 1'b0) else $error("reserved bit set");
  chk_write_to_precharge_delay_never_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[`MTC_WRITE_TO_PRECHARGE_DELAY_HI:`MTC_WRITE_TO_PRECHARGE_DELAY_LO] != `MTC_WRITE_TO_PRECHARGE_DELAY_RSVD) else $error("reserved delay code");
  chk_self_ignores_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (rf_q == RF_SELF) |=> !refresh_start) else $error("refresh started in self-refresh");
  chk_self_waits_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(self_refresh_active) |-> !$past(bus_cycle_active)) else $error("self entry on busy");
  chk_tick_ends_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    (rf_q == RF_IDLE && tick_ok && !want_self && bus_cycle_active) |=> bus_end_req)
    else $error("tick did not end bus cycle");
  chk_end_then_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (rf_q == RF_ENDING && rf_enabled && !bus_cycle_active) |=> (refresh_start && !bus_end_req))
    else $error("no refresh after ended bus cycle");
  chk_idle_tick_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    (rf_q == RF_IDLE && tick_ok && !want_self && !bus_cycle_active) |=> refresh_start)
    else $error("idle tick gave no refresh");
  chk_refresh_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rf_enabled && rf_q == RF_IDLE) |=> !refresh_start) else $error("refresh while off");
  chk_sdram_bursts: assert property (@(posedge aclk) disable iff (!aresetn)
    (is_sdram && $stable(mem_kind)) |=> timing.burst_enable) else $error("sdram not burst");
  chk_edo_dram_only: assert property (@(posedge aclk) disable iff (!aresetn)
    timing.sample_rising |-> ($past(is_dram) && $past(ctrl_q[`MTC_EDO_BIT])))
    else $error("rising sampling off dram");
  chk_write_holdoff: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_wr && gap_wr >= 4'h2) |=> activate_hold [*2]) else $error("write hold-off short");
  chk_refresh_holdoff: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_ar |=> activate_hold [*3]) else $error("auto-refresh hold-off short");

  cov_self_entry: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(self_refresh_active));
  cov_end_then_refresh: cover property (@(posedge aclk) disable iff (!aresetn)
    bus_end_req ##1 refresh_start);
  cov_write_holdoff: cover property (@(posedge aclk) disable iff (!aresetn)
    ld_wr ##1 activate_hold);
endmodule : mtc_top

// [common/mtc_regs.svh]
// register offsets, field positions, reset values and cycle bases
// of the memory timing control block; included by the package, mtc_top and the testbench.
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

`define MTC_ADDR_W        12
`define MTC_CTRL_OFFSET   12'h000
`define MTC_STAT_OFFSET   12'h004

`define MTC_CTRL_W        16
`define MTC_CTRL_RESET    16'h0000
`define MTC_CTRL_WMASK    16'hff7f

`define MTC_TPC_HI        15
`define MTC_TPC_LO        14
`define MTC_RCD_HI        13
`define MTC_RCD_LO        12
`define MTC_WRITE_TO_PRECHARGE_DELAY_HI       11
`define MTC_WRITE_TO_PRECHARGE_DELAY_LO       10
`define MTC_REFRESH_ROW_ASSERT_TIME_HI       9
`define MTC_REFRESH_ROW_ASSERT_TIME_LO       8
`define MTC_RSVD_BIT      7
`define MTC_BURST_BIT     6
`define MTC_WIDTH_BIT     5
`define MTC_AMX_HI        4
`define MTC_AMX_LO        3
`define MTC_REFRESH_ON_BIT      2
`define MTC_KIND_BIT      1
`define MTC_EDO_BIT       0

`define MTC_WRITE_TO_PRECHARGE_DELAY_RSVD     2'h3

`define MTC_STAT_SELF     0
`define MTC_STAT_PEND     1
`define MTC_STAT_HOLD     2
`define MTC_STAT_WAITSR   3

`define MTC_TPC_BASE      4'h1
`define MTC_TPC_SR_BASE   4'h2
`define MTC_RCD_BASE      3'h1
`define MTC_WRITE_TO_PRECHARGE_DELAY_BASE     2'h1
`define MTC_REFRESH_ROW_ASSERT_TIME_BASE     3'h2
`define MTC_DRAM_COL_BASE 4'h8

`define MTC_SDRAM_SHIFT0  4'h8
`define MTC_SDRAM_SHIFT1  4'h9
`define MTC_SDRAM_SHIFT2  4'ha
`define MTC_SDRAM_SHIFT3  4'h8

`define MTC_RESP_OKAY     2'h0
`define MTC_RESP_SLVERR   2'h2

`endif

// [common/mtc_pkg.sv]
// types shared by the memory timing control block.
// assumes mtc_regs.svh is on the include path.
package mtc_pkg;
  `include "mtc_regs.svh"

  typedef enum logic [1:0] {
    MK_NORMAL = 2'b00,
    MK_DRAM   = 2'b01,
    MK_SDRAM  = 2'b10,
    MK_PSRAM  = 2'b11
  } mtc_mem_kind_t;

  typedef enum logic [1:0] {
    RF_IDLE   = 2'b00,
    RF_ENDING = 2'b01,
    RF_SRWAIT = 2'b10,
    RF_SELF   = 2'b11
  } mtc_rf_state_t;

  typedef struct packed {
    logic [3:0] precharge_cycles;
    logic [2:0] row_to_column_delay;
    logic [1:0] write_to_precharge_delay;
    logic [2:0] refresh_row_assert_time;
    logic       burst_enable;
    logic       memory_width_32;
    logic [3:0] row_shift;
    logic       sample_rising;
    logic       ras_negate_half_delay;
  } mtc_timing_t;
endpackage : mtc_pkg

// [design/mtc_gap_timer.sv]
// hold-off timer: counts down the longest gap loaded into it.
// assumes loads are single-cycle pulses synchronous to aclk.
`timescale 1ns/10ps
module mtc_gap_timer #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              busy
);
  if (W < 4) begin : g_bad_width
    $error("mtc_gap_timer: W must be at least 4");
  end

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic [W-1:0] dec;
  logic         busy_q;

  // a new gap never shortens one already running
  assign dec     = (count_q != '0) ? W'(count_q - 1'b1) : '0;
  assign count_d = (load && (value > dec)) ? value : dec;
  assign busy    = busy_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      busy_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q  <= (count_d != '0);
    end
  end

  chk_gap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (load && value != '0) |=> busy) else $error("gap timer did not start");
endmodule : mtc_gap_timer

// [test/mtc_mem_model.sv]
// external memory side: runs bus cycles and reports row or enable negation.
// assumes start is a one-cycle request made while no bus cycle is running.
`timescale 1ns/10ps
module mtc_mem_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic [5:0] len,
  input  wire logic       bus_end_req,
  output logic            bus_cycle_active,
  output logic            precharge_done
);
  logic [5:0] left_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_cycle_active <= 1'b0;
      left_q           <= 6'h00;
      precharge_done   <= 1'b0;
    end else begin
      precharge_done <= 1'b0;
      if (start && !bus_cycle_active) begin
        bus_cycle_active <= 1'b1;
        left_q           <= len;
      end else if (bus_cycle_active) begin
        left_q <= left_q - 6'h01;
        // an end request cuts the cycle short so a refresh can follow
        if (left_q == 6'h01 || bus_end_req) begin
          bus_cycle_active <= 1'b0;
          precharge_done   <= 1'b1; // negation opens the precharge gap
        end
      end
    end
  end
endmodule : mtc_mem_model

// [test/test_mtc_top.sv]
// self-checking bench for the memory timing control block.
// assumes a memory model on the bus side and an AXI4-Lite master in the bench.
`timescale 1ns/10ps
`include "mtc_regs.svh"
module test_mtc_top;
  import mtc_pkg::*;
  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp;
  mtc_mem_kind_t kind;
  logic          tick, wend, aref, start, active, pdone, hold, rstart, endreq, selfr;
  logic [5:0]    len;
  mtc_timing_t   timing;
  int            n_fail, check_count, n_hold, n_start, i_start, n_self, n_bad, i_idle;

  mtc_top #(.TIMER_W(4)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mem_kind(kind), .bus_cycle_active(active),
    .refresh_tick(tick), .precharge_done(pdone), .sdram_write_end(wend),
    .sdram_autorefresh(aref), .timing(timing), .activate_hold(hold),
    .refresh_start(rstart), .bus_end_req(endreq), .self_refresh_active(selfr));
  mtc_mem_model mem (.aclk(aclk), .aresetn(aresetn), .start(start), .len(len),
    .bus_end_req(endreq), .bus_cycle_active(active), .precharge_done(pdone));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] d);
    int i;
    awaddr <= `MTC_CTRL_OFFSET;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("write done", 32'h1, 32'(i < 40));
    chk("write resp", 32'h0, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    chk("read done", 32'h1, 32'(i < 40));
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
    // one idle edge keeps back-to-back reads from driving rready twice in a step
    @(posedge aclk);
  endtask : rd

  // raises the tick, write end and auto-refresh bits chosen by ev for one cycle, then tallies outputs
  task automatic watch(input logic [2:0] ev, input int n);
    int i;
    {tick, wend, aref} <= ev;
    {n_hold, n_start, i_start, n_self, n_bad, i_idle} = '0;
    for (i = 1; i <= n; i++) begin
      @(posedge aclk);
      {tick, wend, aref} <= 3'b000;
      #1;
      if (hold === 1'b1) n_hold++;
      if (rstart === 1'b1) n_start++;
      if (rstart === 1'b1 && i_start == 0) i_start = i;
      if (selfr === 1'b1) n_self++;
      if ((rstart === 1'b1 || selfr === 1'b1) && active === 1'b1) n_bad++;
      if (active !== 1'b1 && i_idle == 0) i_idle = i;
    end
  endtask : watch

  task automatic go(input logic [5:0] n);
    len <= n;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
  endtask : go

  function automatic mtc_timing_t exp_t(input mtc_mem_kind_t k, input logic [15:0] c);
    mtc_timing_t e;
    logic        dram;
    logic [3:0]  sd;
    dram = (k == MK_DRAM);
    e.precharge_cycles = {2'b00, c[15:14]} + 4'h1;
    e.row_to_column_delay = {1'b0, c[13:12]} + 3'h1;
    e.write_to_precharge_delay = c[11:10] + 2'h1;
    e.refresh_row_assert_time = {1'b0, c[9:8]} + 3'h2;
    e.burst_enable = c[6] | (k == MK_SDRAM);
    e.memory_width_32 = c[5];
    sd = c[4] ? (c[3] ? `MTC_SDRAM_SHIFT3 : `MTC_SDRAM_SHIFT2) :
                (c[3] ? `MTC_SDRAM_SHIFT1 : `MTC_SDRAM_SHIFT0);
    e.row_shift = dram ? 4'h8 + {2'b00, c[4:3]} : (k == MK_SDRAM) ? sd : 4'h0;
    e.sample_rising = c[0] & dram;
    e.ras_negate_half_delay = c[0] & dram;
    return e;
  endfunction : exp_t

  task automatic t_reset;
    logic [15:0] d;
    logic [1:0]  r;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`MTC_CTRL_OFFSET, d, r);
    chk("ctrl reset", 32'h0, {16'h0, d});
    rd(12'h010, d, r);
    chk("unmapped resp", {30'h0, `MTC_RESP_SLVERR}, {30'h0, r});
    $display("done reset");
  endtask : t_reset

  task automatic t_fields;
    logic [15:0] d;
    logic [1:0]  r;
    logic [15:0] v;
    int          a;
    kind <= MK_DRAM;
    wr(16'hb6f9);
    rd(`MTC_CTRL_OFFSET, d, r);
    chk("bit 7", 32'hb679, {16'h0, d});
    chk("dram timing", {12'h0, exp_t(MK_DRAM, 16'hb679)}, {12'h0, timing});
    wr(16'hbef9);
    rd(`MTC_CTRL_OFFSET, d, r);
    chk("write_to_precharge_delay 11", 32'hb679, {16'h0, d});
    kind <= MK_SDRAM;
    for (a = 0; a < 4; a++) begin
      v = {11'h001, a[1:0], 3'h0};
      wr(v); // width 32 for synchronous parts
      @(posedge aclk);
      chk("sdram timing", {12'h0, exp_t(MK_SDRAM, v)}, {12'h0, timing});
    end
    $display("done fields");
  endtask : t_fields

  task automatic t_hold;
    int c;
    for (c = 0; c < 4; c++) begin
      kind <= c[0] ? MK_PSRAM : MK_DRAM;
      wr({c[1:0], 14'h0});
      go(6'h01); // bus cycles only once the word is set up
      watch(3'b000, 20);
      chk("precharge hold", 32'(c + 1), 32'(n_hold));
    end
    kind <= MK_SDRAM;
    wr(16'h4b20);
    watch(3'b010, 20);
    chk("write hold", 32'd5, 32'(n_hold));
    watch(3'b001, 20);
    chk("autorefresh hold", 32'd7, 32'(n_hold));
    $display("done hold");
  endtask : t_hold

  task automatic t_refresh;
    kind <= MK_DRAM;
    wr(16'h8000); // timing fields set once after reset
    watch(3'b100, 10);
    chk("refresh off", 32'd0, 32'(n_start));
    wr(16'h8004);
    watch(3'b100, 10);
    chk("refresh idle", 32'd1, 32'(i_start));
    go(6'h28);
    repeat (2) @(posedge aclk);
    watch(3'b100, 20);
    chk("refresh count", 32'd1, 32'(n_start));
    chk("refresh in cycle", 32'd0, 32'(n_bad));
    chk("cycle cut", 32'd1, 32'(i_idle < 5));
    $display("done refresh");
  endtask : t_refresh

  task automatic t_self;
    logic [15:0] d;
    logic [1:0]  r;
    go(6'h08);
    wr(16'h8006); // other fields rewritten with refresh bits
    watch(3'b100, 20);
    chk("self entered", 32'd1, 32'(n_self > 0));
    chk("self in cycle", 32'd0, 32'(n_bad));
    chk("tick in self", 32'd0, 32'(n_start));
    watch(3'b100, 5);
    chk("tick while self", 32'd0, 32'(n_start));
    chk("self held", 32'd5, 32'(n_self));
    rd(`MTC_STAT_OFFSET, d, r);
    chk("status self", 32'h1, {31'h0, d[`MTC_STAT_SELF]});
    wr(16'h8000);
    watch(3'b000, 20);
    chk("self exit hold", 32'd8, 32'(n_hold));
    $display("done self");
  endtask : t_self

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick, wend, aref, start} = '0;
    {awaddr, araddr, wdata, wstrb, len} = '0;
    kind = MK_NORMAL;
    t_reset();
    t_fields();
    t_reset();
    t_hold();
    t_reset();
    t_refresh();
    t_self();
    summarize();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    summarize();
  end
endmodule : test_mtc_top
